// *** rtl/eeprom_program_erase_control.sv ***
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module eeprom_program_erase_control #(
  parameter int unsigned PROG_TICKS = eeprom_pkg::PROG_TICKS  // Ticks per modify cycle.
) (
  input  wire logic                        mclk,            // System clock.
  input  wire logic                        rst_b,           // Synchronous reset, low.
  input  wire logic                        psel,            // APB select.
  input  wire logic                        penable,         // APB enable.
  input  wire logic                        pwrite,          // APB direction.
  input  wire logic [9:0]                  paddr,           // APB byte address.
  input  wire logic [31:0]                 pwdata,          // APB write data.
  output logic                             pready,          // APB ready.
  output logic [31:0]                      prdata,          // APB read data.
  output logic                             pslverr,         // APB error.
  input  wire logic                        special_mode_n,  // Low in special mode.
  input  wire logic [15:0]                 shadow_word,     // Stored shadow word.
  input  wire eeprom_pkg::array_write_type arr_wr,          // CPU array write.
  input  wire logic [9:0]                  rd_addr,         // CPU array read offset.
  input  wire logic [7:0]                  rd_array_byte,   // Byte from regular array.
  output logic [7:0]                       rd_byte,         // Mapped read byte.
  output eeprom_pkg::array_op_type         op,              // Command to the macro.
  output logic                             debug_lockout_disable, // Config bit.
  output logic                             flash_open,      // Config bit.
  output logic                             wait_stop        // Stop in wait.
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } state_type;

  localparam int TICK_W = $clog2(PROG_TICKS + 1);

  if (PROG_TICKS < 1) begin : g_bad_ticks
    $error("PROG_TICKS must be at least one");
  end

  state_type   state_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  prot_q;
  logic [7:0]  cfg_q;
  logic [9:0]  div_q;
  logic        div_high_locked_q;
  logic        div_low_locked_q;
  logic        lock_written_q;
  logic        load_q;
  logic [9:0]  lat_addr_q;
  logic [15:0] lat_data_q;
  logic        lat_word_q;
  logic        lat_valid_q;
  logic [9:0]  pre_cnt_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic [31:0] prdata_q;
  logic [7:0]  rd_byte_q;

  // Region index lookup: which protect bit guards an offset.
  function automatic logic [4:0] region_mask(input logic [9:0] ofs);
    if (ofs <= eeprom_pkg::OFS_BP4_END) begin
      return 5'h10;
    end else if (ofs <= eeprom_pkg::OFS_BP3_END) begin
      return 5'h08;
    end else if (ofs <= eeprom_pkg::OFS_BP2_END) begin
      return 5'h04;
    end else if (ofs <= eeprom_pkg::OFS_BP1_END) begin
      return 5'h02;
    end else begin
      return 5'h01;
    end
  endfunction

  // True when an offset falls on the shadow word while it is mapped in.
  function automatic logic on_shadow(input logic [9:0] ofs, input logic disable_bit);
    return !disable_bit && (ofs[9:1] == eeprom_pkg::OFS_SHADOW_HIGH[9:1]);
  endfunction

  // Bus decode.
  logic [7:0] idx;
  logic       aligned;
  logic       mapped;
  logic       acc_wr;
  logic       sel_ctrl;
  logic       sel_prot;
  logic       sel_cfg;
  logic       sel_divh;
  logic       sel_divl;
  logic       special;
  logic       pgm;
  logic       latch;
  logic       div_zero;

  assign idx      = paddr[9:2];
  assign aligned  = (paddr[1:0] == 2'h0);
  assign sel_ctrl = aligned && (idx == eeprom_pkg::IDX_PROGRAM_CTRL);
  assign sel_prot = aligned && (idx == eeprom_pkg::IDX_BLOCK_PROTECT);
  assign sel_cfg  = aligned && (idx == eeprom_pkg::IDX_MODULE_CONFIG);
  assign sel_divh = aligned && (idx == eeprom_pkg::IDX_DIV_HIGH);
  assign sel_divl = aligned && (idx == eeprom_pkg::IDX_DIV_LOW);
  assign mapped   = sel_ctrl || sel_prot || sel_cfg || sel_divh || sel_divl;
  assign acc_wr   = psel && penable && pwrite && mapped;
  assign special  = !special_mode_n;
  assign pgm      = ctrl_q[eeprom_pkg::POS_PGM];
  assign latch    = ctrl_q[eeprom_pkg::POS_LATCH];
  assign div_zero = (div_q == 10'h000);

  // Zero-wait slave; read data is captured in the setup cycle so it leaves a flop.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      if (sel_ctrl) prdata_q[7:0] <= ctrl_q;
      if (sel_prot) prdata_q[7:0] <= prot_q;
      if (sel_cfg)  prdata_q[7:0] <= cfg_q;
      if (sel_divh) prdata_q[1:0] <= div_q[9:8];
      if (sel_divl) prdata_q[7:0] <= div_q[7:0];
    end
  end

  // Modify target checks on the latched location.
  logic       tgt_shadow;
  logic       blocked;
  logic       pgm_set;
  logic       start_go;
  logic       tick;
  logic       finish;
  eeprom_pkg::op_kind_type kind;

  assign tgt_shadow = on_shadow(lat_addr_q, cfg_q[6]);

  // Erase granularity from the control bits.
  always_comb begin
    kind = eeprom_pkg::OP_PROGRAM;
    if (ctrl_q[eeprom_pkg::POS_ERASE]) begin
      if (ctrl_q[eeprom_pkg::POS_SINGLE]) begin
        kind = eeprom_pkg::OP_ERASE_LOC;
      end else if (ctrl_q[eeprom_pkg::POS_ROW]) begin
        kind = eeprom_pkg::OP_ERASE_ROW;
      end else begin
        kind = eeprom_pkg::OP_ERASE_BULK;
      end
    end
  end

  // A bulk erase sweeps every block, so any of block protect bits 4:0 blocks it too.
  assign blocked = (tgt_shadow && prot_q[eeprom_pkg::POS_SHADOW_PROT])
                || ((region_mask(lat_addr_q) & prot_q[4:0]) != 5'h00)
                || ((kind == eeprom_pkg::OP_ERASE_BULK) && (prot_q[4:0] != 5'h00))
                || (((kind == eeprom_pkg::OP_ERASE_ROW) || (kind == eeprom_pkg::OP_ERASE_BULK))
                    && ctrl_q[eeprom_pkg::POS_BULK_GUARD]);

  assign pgm_set  = acc_wr && sel_ctrl && pwdata[eeprom_pkg::POS_PGM] && latch && !pgm;
  assign start_go = pgm_set && lat_valid_q && !blocked && !div_zero;
  assign tick     = (state_q == ST_RUN) && (pre_cnt_q == div_q - 10'h001);
  assign finish   = tick && (tick_cnt_q == TICK_W'(PROG_TICKS - 1));

  // Program control register; hardware clear of program enable comes last.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_q <= eeprom_pkg::RST_PROGRAM_CTRL;
    end else begin
      if (acc_wr && sel_ctrl) begin
        if (!pgm) begin
          ctrl_q[eeprom_pkg::POS_AUTO]   <= pwdata[eeprom_pkg::POS_AUTO];
          ctrl_q[eeprom_pkg::POS_SINGLE] <= pwdata[eeprom_pkg::POS_SINGLE];
          ctrl_q[eeprom_pkg::POS_ROW]    <= pwdata[eeprom_pkg::POS_ROW];
          ctrl_q[eeprom_pkg::POS_ERASE]  <= pwdata[eeprom_pkg::POS_ERASE];
          if (!prot_q[0] || !cfg_q[eeprom_pkg::POS_PROT_LOCK]) begin
            if (!cfg_q[eeprom_pkg::POS_PROT_LOCK]) begin
              ctrl_q[eeprom_pkg::POS_BULK_GUARD] <= pwdata[eeprom_pkg::POS_BULK_GUARD];
            end
          end
          if (!div_zero) begin
            ctrl_q[eeprom_pkg::POS_LATCH] <= pwdata[eeprom_pkg::POS_LATCH];
          end
        end
        if (!pwdata[eeprom_pkg::POS_PGM]) begin
          ctrl_q[eeprom_pkg::POS_PGM] <= 1'b0;
        end else if (latch) begin
          ctrl_q[eeprom_pkg::POS_PGM] <= 1'b1;
        end
      end
      if (finish && ctrl_q[eeprom_pkg::POS_AUTO]) begin
        ctrl_q[eeprom_pkg::POS_PGM] <= 1'b0;
      end
    end
  end

  // Block protect register.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      prot_q <= eeprom_pkg::RST_BLOCK_PROTECT;
    end else if (acc_wr && sel_prot && !pgm && !cfg_q[eeprom_pkg::POS_PROT_LOCK]) begin
      prot_q <= {pwdata[7], 2'b00, pwdata[4:0]};
    end
  end

  // Module config; the high nibble is filled from the shadow word after reset.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_q          <= {4'h0, eeprom_pkg::RST_CONFIG_LOW};
      lock_written_q <= 1'b0;
    end else if (load_q) begin
      cfg_q[7:4] <= shadow_word[15:12];
    end else if (acc_wr && sel_cfg) begin
      if (special) begin
        cfg_q[7:6] <= pwdata[7:6];
        cfg_q[4]   <= pwdata[4];
      end else if (!pwdata[4]) begin
        cfg_q[4] <= 1'b0;
      end
      cfg_q[eeprom_pkg::POS_WAIT_STOP] <= pwdata[eeprom_pkg::POS_WAIT_STOP];
      cfg_q[eeprom_pkg::POS_DUMMY]     <= pwdata[eeprom_pkg::POS_DUMMY];
      if (special || !lock_written_q) begin
        cfg_q[eeprom_pkg::POS_PROT_LOCK] <= pwdata[eeprom_pkg::POS_PROT_LOCK];
        lock_written_q                   <= 1'b1;
      end
    end
  end

  // Divider: loaded from the shadow word, then write-once in normal mode.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_q             <= 10'h000;
      div_high_locked_q <= 1'b0;
      div_low_locked_q  <= 1'b0;
      load_q            <= 1'b1;
    end else if (load_q) begin
      div_q  <= {shadow_word[9:8], shadow_word[7:0]};
      load_q <= 1'b0;
    end else if (acc_wr && !latch) begin
      if (sel_divh && (special || !div_high_locked_q)) begin
        div_q[9:8]        <= pwdata[1:0];
        div_high_locked_q <= 1'b1;
      end
      if (sel_divl && (special || !div_low_locked_q)) begin
        div_q[7:0]       <= pwdata[7:0];
        div_low_locked_q <= 1'b1;
      end
    end
  end

  // Address and data latches; frozen for the whole cycle.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lat_addr_q  <= 10'h000;
      lat_data_q  <= 16'h0000;
      lat_word_q  <= 1'b0;
      lat_valid_q <= 1'b0;
    end else if (!latch) begin
      lat_valid_q <= 1'b0;
    end else if (arr_wr.wr && !pgm) begin
      lat_addr_q  <= arr_wr.word ? {arr_wr.addr[9:1], 1'b0} : arr_wr.addr;
      lat_data_q  <= arr_wr.data;
      lat_word_q  <= arr_wr.word;
      lat_valid_q <= 1'b1;
    end
  end

  // Cycle sequencer; software clearing program enable aborts a running cycle.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start_go) state_q <= ST_RUN;
        ST_RUN:  if (!pgm) state_q <= ST_IDLE; else if (finish) state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Self-time prescaler and tick counter; a tick lasts the divider value in clocks.
  always_ff @(posedge mclk) begin
    if (!rst_b || state_q != ST_RUN) begin
      pre_cnt_q  <= 10'h000;
      tick_cnt_q <= '0;
    end else if (tick) begin
      pre_cnt_q  <= 10'h000;
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end else begin
      pre_cnt_q <= pre_cnt_q + 10'h001;
    end
  end

  // Read path with shadow overlay, registered.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_byte_q <= 8'h00;
    end else if (on_shadow(rd_addr, cfg_q[6])) begin
      rd_byte_q <= rd_addr[0] ? shadow_word[7:0] : shadow_word[15:8];
    end else begin
      rd_byte_q <= rd_array_byte;
    end
  end

  // Macro command outputs come straight from latches and state flops.
  always_comb begin
    op.start  = (state_q == ST_RUN) && (pre_cnt_q == 10'h000) && (tick_cnt_q == '0);
    op.active = (state_q == ST_RUN);
    op.done   = (state_q == ST_DONE);
    op.kind   = kind;
    op.addr   = lat_addr_q;
    op.data   = lat_data_q;
    op.word   = lat_word_q;
    op.shadow = tgt_shadow;
  end

  assign rd_byte               = rd_byte_q;
  assign debug_lockout_disable = cfg_q[7];
  assign flash_open            = cfg_q[4];
  assign wait_stop             = cfg_q[eeprom_pkg::POS_WAIT_STOP];

  // Checks.
  sequence s_ctrl_both;
    acc_wr && sel_ctrl && pwdata[1] && pwdata[0] && !latch && !pgm && !div_zero;
  endsequence
  sequence s_cycle_end;
    finish && ctrl_q[eeprom_pkg::POS_AUTO];
  endsequence

  property p_prot_frozen;
    @(posedge mclk) disable iff (!rst_b)
      (acc_wr && sel_prot && (pgm || cfg_q[1])) |=> $stable(prot_q);
  endproperty
  a_prot_frozen: assert property (p_prot_frozen) else $error("protect written while locked");

  property p_shadow_refuse;
    @(posedge mclk) disable iff (!rst_b)
      (pgm_set && tgt_shadow && prot_q[7]) |=> !op.active [*2];
  endproperty
  a_shadow_refuse: assert property (p_shadow_refuse) else $error("shadow modified while protected");

  property p_region;
    @(posedge mclk) disable iff (!rst_b)
      op.start |-> ((region_mask(op.addr) & prot_q[4:0]) == 5'h00);
  endproperty
  a_region: assert property (p_region) else $error("protected block modified");

  property p_bulk_guard;
    @(posedge mclk) disable iff (!rst_b)
      (op.start && (op.kind == eeprom_pkg::OP_ERASE_ROW || op.kind == eeprom_pkg::OP_ERASE_BULK))
        |-> !ctrl_q[7];
  endproperty
  a_bulk_guard: assert property (p_bulk_guard) else $error("row or bulk erase under guard");

  property p_auto_clear;
    @(posedge mclk) disable iff (!rst_b)
      s_cycle_end |=> !pgm ##1 (state_q == ST_IDLE);
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("program enable not auto cleared");

  property p_program_kind;
    @(posedge mclk) disable iff (!rst_b)
      (op.active && !ctrl_q[2]) |-> (op.kind == eeprom_pkg::OP_PROGRAM);
  endproperty
  a_program_kind: assert property (p_program_kind) else $error("erase without erase select");

  property p_latch_first;
    @(posedge mclk) disable iff (!rst_b)
      s_ctrl_both |=> (latch && !pgm);
  endproperty
  a_latch_first: assert property (p_latch_first) else $error("enable set with latch");

  property p_latch_hold;
    @(posedge mclk) disable iff (!rst_b)
      (pgm && $past(pgm)) |-> ($stable(lat_addr_q) && $stable(lat_data_q));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latches changed in cycle");

  property p_div_lock;
    @(posedge mclk) disable iff (!rst_b)
      (acc_wr && sel_divl && special_mode_n && div_low_locked_q) |=> $stable(div_q[7:0]);
  endproperty
  a_div_lock: assert property (p_div_lock) else $error("locked divider overwritten");

  property p_run_len;
    @(posedge mclk) disable iff (!rst_b)
      (op.start && div_q == 10'h001 && PROG_TICKS > 2) |-> op.active [*2];
  endproperty
  a_run_len: assert property (p_run_len) else $error("cycle ended too early");

endmodule // eeprom_program_erase_control

`default_nettype wire

// *** rtl/eeprom_pkg.sv ***
package eeprom_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_DIV_HIGH      = 8'hee;
  localparam logic [7:0] IDX_DIV_LOW       = 8'hef;
  localparam logic [7:0] IDX_MODULE_CONFIG = 8'hf0;
  localparam logic [7:0] IDX_BLOCK_PROTECT = 8'hf1;
  localparam logic [7:0] IDX_PROGRAM_CTRL  = 8'hf3;

  // Program control field positions.
  localparam int POS_BULK_GUARD = 7;
  localparam int POS_AUTO       = 5;
  localparam int POS_SINGLE     = 4;
  localparam int POS_ROW        = 3;
  localparam int POS_ERASE      = 2;
  localparam int POS_LATCH      = 1;
  localparam int POS_PGM        = 0;
  // Block protect and module config field positions.
  localparam int POS_SHADOW_PROT = 7;
  localparam int POS_PROT_LOCK   = 1;
  localparam int POS_WAIT_STOP   = 2;
  localparam int POS_DUMMY       = 0;

  // Reset values.
  localparam logic [7:0] RST_PROGRAM_CTRL  = 8'h80;
  localparam logic [7:0] RST_BLOCK_PROTECT = 8'h9f;
  localparam logic [3:0] RST_CONFIG_LOW    = 4'hc;

  // Array offsets inside the 1-Kbyte space.
  localparam logic [9:0] OFS_SHADOW_HIGH = 10'h3c0;
  localparam logic [9:0] OFS_BP4_END     = 10'h1ff;
  localparam logic [9:0] OFS_BP3_END     = 10'h2ff;
  localparam logic [9:0] OFS_BP2_END     = 10'h37f;
  localparam logic [9:0] OFS_BP1_END     = 10'h3bf;

  // Cycle timing: program or erase time over one self-time tick.
  localparam int unsigned PROG_TIME_NS = 10000000;
  localparam int unsigned TICK_TIME_NS = 35000;
  localparam int unsigned PROG_TICKS   = PROG_TIME_NS / TICK_TIME_NS;

  typedef enum logic [1:0] {
    OP_PROGRAM    = 2'h0,
    OP_ERASE_LOC  = 2'h1,
    OP_ERASE_ROW  = 2'h2,
    OP_ERASE_BULK = 2'h3
  } op_kind_type;

  // A CPU write into the array space.
  typedef struct packed {
    logic        wr;
    logic [9:0]  addr;
    logic [15:0] data;
    logic        word;
  } array_write_type;

  // A modify command towards the array macro.
  typedef struct packed {
    logic        start;
    logic        active;
    logic        done;
    op_kind_type kind;
    logic [9:0]  addr;
    logic [15:0] data;
    logic        word;
    logic        shadow;
  } array_op_type;

endpackage

// *** rtl/unused_placeholder_none.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [7:0] CTL = eeprom_pkg::IDX_PROGRAM_CTRL;
  localparam logic [7:0] BPR = eeprom_pkg::IDX_BLOCK_PROTECT;
  localparam logic [7:0] CFG = eeprom_pkg::IDX_MODULE_CONFIG;
  localparam logic [7:0] DVL = eeprom_pkg::IDX_DIV_LOW;
  localparam logic [7:0] DVH = eeprom_pkg::IDX_DIV_HIGH;
  logic                        mclk;
  logic                        rst_b;
  logic                        psel;
  logic                        penable;
  logic                        pwrite;
  logic [9:0]                  paddr;
  logic [31:0]                 pwdata;
  logic                        pready;
  logic [31:0]                 prdata;
  logic                        pslverr;
  logic                        last_err;
  logic                        special_mode_n;
  logic [15:0]                 shadow_word;
  eeprom_pkg::array_write_type arr_wr;
  logic [9:0]                  rd_addr;
  logic [7:0]                  rd_array_byte;
  logic [7:0]                  rd_byte;
  eeprom_pkg::array_op_type    op;
  logic                        debug_lockout_disable;
  logic                        flash_open;
  logic                        wait_stop;
  int                          mismatches = 0;
  int                          n_compared = 0;
  int                          cycles = 0;
  int                          k;
  // Each row: control value, latched target, expected kind, whether a cycle may start.
  logic [7:0] ctl_v [7]  = '{8'h22, 8'h22, 8'hae, 8'h3a, 8'h36, 8'h2e, 8'h26};
  logic [9:0] adr_v [7]  = '{10'h010, 10'h3d0, 10'h020, 10'h020, 10'h021, 10'h040, 10'h000};
  logic [1:0] kind_v [7] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
  logic       go_v [7]   = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  // A short cycle count keeps each modify cycle under a hundred clocks.
  eeprom_program_erase_control #(.PROG_TICKS(3)) dut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .special_mode_n(special_mode_n), .shadow_word(shadow_word), .arr_wr(arr_wr),
    .rd_addr(rd_addr), .rd_array_byte(rd_array_byte), .rd_byte(rd_byte), .op(op),
    .debug_lockout_disable(debug_lockout_disable), .flash_open(flash_open),
    .wait_stop(wait_stop));

  // Free-running system clock.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Cuts a hung wait short so the verdict is still printed.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    apb(idx, 1'b1, d, q);
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] e, input string nm);
    logic [31:0] q;
    apb(idx, 1'b0, 8'h00, q);
    check(nm, q, {24'h0, e});
  endtask

  // A byte write into the array space lasts one cycle.
  task automatic aw(input logic [9:0] a);
    @(posedge mclk);
    arr_wr <= {1'b1, a, 16'h00a5, 1'b0};
    @(posedge mclk);
    arr_wr <= '0;
  endtask

  // Main sequence: reset, load checks, a table of cycles, then locks and mapping.
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    special_mode_n = 1'b1;
    shadow_word = 16'hde03;
    arr_wr = '0;
    rd_addr = '0;
    rd_array_byte = 8'h5a;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    rc(CTL, 8'h80, "ctrl_reset");
    rc(BPR, eeprom_pkg::RST_BLOCK_PROTECT, "prot_reset");
    rc(DVL, 8'h03, "div_low_load");
    rc(DVH, 8'h02, "div_high_load");
    rc(CFG, 8'hdc, "cfg_load");
    check("cfg_outs", {debug_lockout_disable, flash_open, wait_stop}, 3'h7);
    rc(8'hf2, 8'h00, "unmapped");
    check("pslverr", last_err, 1'b1);
    w(DVH, 8'h00);
    w(DVL, 8'h20);
    w(DVL, 8'h05);
    w(DVH, 8'h03);
    rc(DVL, 8'h20, "div_low_once");
    rc(DVH, 8'h00, "div_high_once");
    w(BPR, 8'h01);
    rc(BPR, 8'h01, "prot_write");
    w(CTL, 8'h03);
    rc(CTL, 8'h02, "ctrl_both");
    for (int i = 0; i < 7; i++) begin
      if (i == 3) w(BPR, 8'h00);
      w(CTL, ctl_v[i]);
      aw(adr_v[i]);
      w(CTL, ctl_v[i] | 8'h01);
      for (k = 0; k < 4 && op.active !== 1'b1; k++) @(posedge mclk);
      check("op_active", op.active, go_v[i]);
      if (go_v[i]) begin
        check("op_kind", op.kind, kind_v[i]);
        check("op_addr", op.addr, adr_v[i]);
        w(CTL, (ctl_v[i] ^ 8'h3c) | 8'h01);
        aw(10'h0aa);
        rc(CTL, ctl_v[i] | 8'h01, "ctrl_frozen");
        check("op_addr_held", op.addr, adr_v[i]);
        w(BPR, 8'h1f);
        rc(BPR, (i < 3) ? 8'h01 : 8'h00, "prot_busy");
        for (k = 0; k < 2000 && op.done !== 1'b1; k++) @(posedge mclk);
        check("op_done", op.done, 1'b1);
      end
      rc(CTL, {ctl_v[i][7:1], ~go_v[i]}, "ctrl_after");
      if (!go_v[i]) w(CTL, ctl_v[i]);
    end
    rd_addr <= 10'h3c0;
    repeat (2) @(posedge mclk);
    check("rd_regular", rd_byte, 8'h5a);
    w(CFG, 8'hde);
    w(BPR, 8'h1f);
    rc(BPR, 8'h00, "prot_locked");
    w(CTL, 8'h80);
    rc(CTL, 8'h00, "guard_locked");
    special_mode_n <= 1'b0;
    w(CFG, 8'h9e);
    repeat (2) @(posedge mclk);
    check("rd_shadow", rd_byte, 8'hde);
    w(DVL, 8'h07);
    rc(DVL, 8'h07, "div_special");
    // A protected shadow word must refuse a cycle and keep program enable set.
    w(CFG, 8'h9c);
    w(BPR, 8'h80);
    w(CTL, 8'h02);
    aw(10'h3c0);
    w(CTL, 8'h03);
    repeat (4) @(posedge mclk);
    check("shadow_refused", op.active, 1'b0);
    rc(CTL, 8'h03, "shadow_pgm_kept");
    end_sim();
  end
endmodule // tb

`default_nettype wire
